//--- fxp_pkg.sv
// Package for the flexible I/O strap and power control block.
// Assumes one 25 MHz clock domain and a synchronous active-low reset.
package fxp_pkg;
  // ---------------------------------------------------------------
  // Widths and clock timing
  // ---------------------------------------------------------------
  localparam int WORD_W = 10;
  localparam int CLK_MHZ = 25;
  localparam int CONV_DIV_W = 4;
  localparam logic [CONV_DIV_W-1:0] CONV_DIV_RST = 4'h0;

  // ---------------------------------------------------------------
  // Register byte addresses (choice, no printed map)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_CFG = 8'h08;

  // Control register fields
  localparam int CTRL_CLONE = 0;
  localparam int CTRL_DIV_LO = 4;
  localparam int CTRL_UPS_LO = 8;
  localparam int CTRL_ECO = 12;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Upsampling codes
  localparam logic [1:0] UPS_X1 = 2'h0;
  localparam logic [1:0] UPS_X2 = 2'h1;
  localparam logic [1:0] UPS_X4 = 2'h2;

  // Interface modes
  typedef enum logic [1:0] {
    FXP_FULL = 2'b00,
    FXP_HD_INTERLEAVED = 2'b01,
    FXP_HD_PARALLEL = 2'b10,
    FXP_CLONE = 2'b11
  } fxp_mode_e;

  // Is an upsampling code legal with an interleaved bus
  function automatic logic fxp_ups_ok(input logic [1:0] code);
    return (code == UPS_X2) || (code == UPS_X4);
  endfunction
endpackage

//--- fxp_sync2.sv
// Two-flop synchroniser for a vector of pin inputs.
// Assumes the pins are asynchronous to clk.
`timescale 1ns/1ns
module fxp_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic clkEn,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] pinSync
);
  logic [W-1:0] stage1;

  // Two-stage capture, first stage read only by the second
  always_ff @(posedge clk) begin
    if (clkEn) begin
      stage1 <= pinIn;
      pinSync <= stage1;
    end
  end
endmodule // fxp_sync2

//--- fxp_clk_div.sv
// Enable generator that divides the core clock for the converter.
// Assumes synchronous active-low reset; ratio is div+1.
`timescale 1ns/1ns
module fxp_clk_div #(
  parameter int DW = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic run,
  input wire logic [DW-1:0] div,
  output logic tick
);
  logic [DW-1:0] cnt;

  // Counts up to div and pulses once per period while running
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt <= '0;
      tick <= 1'b0;
    end else if (clkEn) begin
      if (!run) begin
        cnt <= '0;
        tick <= 1'b0;
      end else if (cnt >= div) begin
        cnt <= '0;
        tick <= 1'b1;
      end else begin
        cnt <= cnt + 1'b1;
        tick <= 1'b0;
      end
    end
  end
endmodule // fxp_clk_div

//--- fxp_flex_io.sv
// Flexible I/O data interface, strap latch and power gating.
// Assumes AXI4-Lite master on clk; all pins pass a two-flop synchroniser.
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ns
// Notes on behaviour
// - Channel marker high sends word to A
// - One output clock rise per accepted sample
// - Divider slows converter clock
// - Two receive words per output clock, one in interleaved mode
// - Receive: channel A lower bus, B upper
// - Straps captured at reset release
// - Receive sleep gates receive clocks
// - Transmit sleep gates transmit, transmit clock output stopped
// - Select high: inputs; low: outputs
// - Select gates only digital clocks
// - Economy strap picks low ADC power
// - Serial enable strap disables other straps
// - Duplex strap low selects half duplex
// - Width strap picks parallel or interleaved
// - Two bits pick upsampling factor
// - Select pin one sets bus direction
module fxp_flex_io #(
  parameter int W = fxp_pkg::WORD_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // Pins
  input wire logic serial_enable_strap,
  input wire logic serial_out_pin,
  input wire logic serial_data_io_pin,
  input wire logic serial_clk_pin,
  input wire logic width_strap_pin,
  input wire logic adc_economy_strap,
  input wire logic select_pin_one,
  input wire logic receive_sleep_pin,
  input wire logic transmit_sleep_pin,
  input wire logic [W-1:0] upper_half_bus_in,
  output logic [W-1:0] upper_half_bus_out,
  output logic upper_half_bus_oe,
  input wire logic [W-1:0] lower_half_bus_in,
  output logic [W-1:0] lower_half_bus_out,
  output logic lower_half_bus_oe,
  output logic buffered_clock_out_pin,
  // Converter side
  input wire logic [W-1:0] adcA,
  input wire logic [W-1:0] adcB,
  output logic adcStrobe,
  output logic [W-1:0] dacA,
  output logic [W-1:0] dacB,
  output logic dacAValid,
  output logic dacBValid,
  output logic adcLowPower,
  output logic rxAnalogOn,
  output logic txAnalogOn,
  output logic [1:0] upsampleFactor,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import fxp_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  localparam int NP = 9 + 2 * W;
  logic [NP-1:0] pinRaw;
  logic [NP-1:0] pinSync;
  assign pinRaw = {serial_enable_strap, serial_out_pin, serial_data_io_pin, serial_clk_pin,
                   width_strap_pin, adc_economy_strap, select_pin_one, receive_sleep_pin,
                   transmit_sleep_pin, upper_half_bus_in, lower_half_bus_in};

  fxp_sync2 #(.W(NP)) uSync (
    .clk(clk),
    .clkEn(clkEn),
    .pinIn(pinRaw),
    .pinSync(pinSync)
  );

  logic sEn, sDup, sUpHi, sUpLo, sWid, sEco, sSel, sRxSleep, sTxSleep;
  logic [W-1:0] sUpper, sLower;
  assign {sEn, sDup, sUpHi, sUpLo, sWid, sEco, sSel, sRxSleep, sTxSleep, sUpper, sLower} = pinSync;

  // ---------------------------------------------------------------
  // Strap latch
  // ---------------------------------------------------------------
  logic inReset;
  logic strapSerial, strapDup, strapWid, strapEco;
  logic [1:0] strapUps;

  // Tracks reset so the release edge is seen
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      inReset <= 1'b1;
    end else if (clkEn) begin
      inReset <= 1'b0;
    end
  end

  // Straps sampled on the first enabled cycle after release, then frozen
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strapSerial <= 1'b0;
      strapDup <= 1'b1;
      strapWid <= 1'b0;
      strapEco <= 1'b0;
      strapUps <= UPS_X2;
    end else if (clkEn && inReset) begin
      strapSerial <= sEn;
      strapDup <= sDup;
      strapWid <= sWid;
      strapEco <= sEco;
      strapUps <= {sUpHi, sUpLo};
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite registers
  // ---------------------------------------------------------------
  logic [31:0] ctrl;
  logic [7:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic awHave, wHave;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  // Effective configuration, declared here because the read decode uses it
  fxp_mode_e mode;
  logic [1:0] ups;
  logic cfgBad;
  logic txSide, rxRun, txRun;

  // Write address and data captured in either order
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      awHave <= 1'b0;
      wHave <= 1'b0;
      awAddr <= '0;
      wData <= '0;
      wStrb <= '0;
    end else if (clkEn) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHave <= 1'b1;
        awAddr <= s_axi_awaddr;
      end else if (s_axi_bvalid && s_axi_bready) begin
        awHave <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end else if (s_axi_bvalid && s_axi_bready) begin
        wHave <= 1'b0;
      end
    end
  end

  // Ready only while the slot is empty and no response pending
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (clkEn) begin
      s_axi_awready <= !awHave && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !wHave && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // Commit write, byte lanes honoured, then respond
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl <= CTRL_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (clkEn) begin
      if (awHave && wHave && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        if (awAddr == ADDR_CTRL) begin
          for (int i = 0; i < 4; i++) begin
            if (wStrb[i]) begin
              ctrl[8*i +: 8] <= wData[8*i +: 8];
            end
          end
          s_axi_bresp <= RESP_OKAY;
        end else if (awAddr == ADDR_STAT || awAddr == ADDR_CFG) begin
          s_axi_bresp <= RESP_OKAY;
        end else begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read decode
  always_comb begin
    next_rdata = '0;
    next_rresp = RESP_OKAY;
    unique case (s_axi_araddr)
      ADDR_CTRL: next_rdata = ctrl;
      ADDR_STAT: next_rdata = {26'h0, mode, sSel, sRxSleep, sTxSleep, cfgBad};
      ADDR_CFG: next_rdata = {26'h0, strapSerial, strapDup, strapWid, strapEco, strapUps};
      default: next_rresp = RESP_SLVERR;
    endcase
  end

  // Read channel, one read at a time
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (clkEn) begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= next_rresp;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Effective configuration
  // ---------------------------------------------------------------

  // Serial-port control replaces straps when enabled
  always_comb begin
    if (strapSerial) begin
      mode = ctrl[CTRL_CLONE] ? FXP_CLONE : FXP_FULL;
      ups = ctrl[CTRL_UPS_LO +: 2];
    end else begin
      ups = strapUps;
      if (strapDup) begin
        mode = FXP_FULL;
      end else if (strapWid) begin
        mode = FXP_HD_INTERLEAVED;
      end else begin
        mode = FXP_HD_PARALLEL;
      end
    end
  end

  // Interleaved modes refuse 1x; data path held off
  assign cfgBad = (mode != FXP_HD_PARALLEL) && !fxp_ups_ok(ups);
  assign txSide = sSel;
  // Clock gating: sleep pins and half-duplex select
  assign rxRun = !sRxSleep && !cfgBad && (mode == FXP_FULL || !txSide);
  assign txRun = !sTxSleep && !cfgBad && (mode == FXP_FULL || txSide);

  // ---------------------------------------------------------------
  // Converter clock divider
  // ---------------------------------------------------------------
  logic adcTick;
  fxp_clk_div #(.DW(CONV_DIV_W)) uDiv (
    .clk(clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .run(rxRun),
    .div(strapSerial ? ctrl[CTRL_DIV_LO +: CONV_DIV_W] : CONV_DIV_RST),
    .tick(adcTick)
  );

  // Static outputs: power, analog enables and factor
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      adcLowPower <= 1'b0;
      rxAnalogOn <= 1'b0;
      txAnalogOn <= 1'b0;
      upsampleFactor <= UPS_X1;
    end else if (clkEn) begin
      adcLowPower <= strapSerial ? ctrl[CTRL_ECO] : strapEco;
      rxAnalogOn <= !sRxSleep;
      txAnalogOn <= !sTxSleep;
      upsampleFactor <= ups;
    end
  end

  // ---------------------------------------------------------------
  // Data path
  // ---------------------------------------------------------------
  logic rxPhase;
  logic txEdge;
  logic txMark;

  // Full duplex keeps the lower bus for receive, so the marker rides on select
  assign txMark = (mode == FXP_FULL) ? sSel : sLower[W-1];

  // Receive: strobe the converter and drive the half buses
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      adcStrobe <= 1'b0;
      rxPhase <= 1'b0;
      upper_half_bus_out <= '0;
      lower_half_bus_out <= '0;
      upper_half_bus_oe <= 1'b0;
      lower_half_bus_oe <= 1'b0;
    end else if (clkEn) begin
      adcStrobe <= adcTick;
      lower_half_bus_oe <= rxRun;
      upper_half_bus_oe <= rxRun && mode != FXP_FULL && mode != FXP_HD_INTERLEAVED;
      if (adcTick) begin
        rxPhase <= !rxPhase;
        if (mode == FXP_FULL || mode == FXP_HD_INTERLEAVED) begin
          lower_half_bus_out <= rxPhase ? adcB : adcA;
        end else begin
          lower_half_bus_out <= adcA;
          upper_half_bus_out <= adcB;
        end
      end
    end
  end

  // Transmit: channel marker steers interleaved words
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dacA <= '0;
      dacB <= '0;
      dacAValid <= 1'b0;
      dacBValid <= 1'b0;
      txEdge <= 1'b0;
    end else if (clkEn) begin
      txEdge <= txRun && !txEdge;
      dacAValid <= 1'b0;
      dacBValid <= 1'b0;
      if (txRun && txEdge) begin
        if (mode == FXP_HD_PARALLEL) begin
          dacA <= sUpper;
          dacB <= sLower;
          dacAValid <= 1'b1;
          dacBValid <= 1'b1;
        end else if (txMark) begin
          dacA <= sUpper;
          dacAValid <= 1'b1;
        end else begin
          dacB <= sUpper;
          dacBValid <= 1'b1;
        end
      end
    end
  end

  // Output clock: receive strobe, or one rise per accepted sample
  // Full duplex always shows the transmit clock here
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      buffered_clock_out_pin <= 1'b0;
    end else if (clkEn) begin
      buffered_clock_out_pin <= (rxRun && mode != FXP_FULL) ? adcTick : txEdge;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_strap_frozen: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && !inReset && !$past(inReset)) |-> $stable(strapDup) && $stable(strapEco))
    else $error("strap changed after reset release");
  a_strap_capture: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && inReset && rst_n) |=> strapEco == $past(sEco))
    else $error("economy strap not captured");
  a_tx_marker: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && txRun && txEdge && mode == FXP_CLONE && sLower[W-1]) |=> dacAValid && !dacBValid)
    else $error("marker high did not steer to A");
  a_tx_one_edge: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && txRun && txEdge && !(rxRun && mode != FXP_FULL)) |=> buffered_clock_out_pin)
    else $error("no output clock rise for sample");
  a_rx_sleep: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && sRxSleep) |=> !adcTick)
    else $error("receive clock ran while asleep");
  a_tx_sleep: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && sTxSleep) |=> !dacAValid && !dacBValid)
    else $error("transmit ran while asleep");
  a_bus_dir: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && sSel && mode != FXP_FULL) |=> !lower_half_bus_oe && !upper_half_bus_oe)
    else $error("bus driven in transmit select");
  a_clone_ups: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == FXP_CLONE && ups == UPS_X1) |-> !txRun && !rxRun)
    else $error("clone mode ran at 1x");
  a_analog_on: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && rst_n && !sRxSleep && sSel) |=> rxAnalogOn)
    else $error("select powered down analog");
  c_tx_a: cover property (@(posedge clk) dacAValid);
  c_tx_b: cover property (@(posedge clk) dacBValid);
  c_rx: cover property (@(posedge clk) adcStrobe && upper_half_bus_oe);
endmodule // fxp_flex_io

//--- fxp_proc_model.sv
// Processor-side model that drives transmit words on the upper half bus and the channel marker on the lower.
// Assumes the bench resolves each bus wire from the device output enables.
`timescale 1ns/1ns
module fxp_proc_model (
  input wire logic clk,
  input wire logic drive,
  input wire logic mark,
  input wire logic [fxp_pkg::WORD_W-1:0] word,
  output logic [fxp_pkg::WORD_W-1:0] upperDrv,
  output logic [fxp_pkg::WORD_W-1:0] lowerDrv
);
  // ---------------------------------------------------------------
  // Bus driver
  // ---------------------------------------------------------------
  initial begin
    upperDrv = 10'h000;
    lowerDrv = 10'h000;
  end
  // Words are held for many cycles, so the rate stays far below the limit
  always @(posedge clk) begin
    if (drive) begin
      upperDrv <= word;
      lowerDrv <= {mark, 9'h000};
    end else begin
      // Released bus toggles between the last value and its inverse
      upperDrv <= ~upperDrv;
      lowerDrv <= ~lowerDrv;
    end
  end
endmodule // fxp_proc_model

//--- fxp_flex_io_tb.sv
// Self-checking bench for the flexible I/O strap and power block.
// Assumes the processor model stands on the half buses.
`timescale 1ns/1ns
module fxp_flex_io_tb;
  import fxp_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic clk = 1'b0, rst_n = 1'b0, serEn = 1'b0, dupS = 1'b1, widS = 1'b1;
  logic ecoS = 1'b1, upsH = 1'b0, upsL = 1'b1, sclk = 1'b0;
  logic selPin = 1'b0, rxSleep = 1'b0, txSleep = 1'b0, drive = 1'b0, mark = 1'b0;
  logic [9:0] word = 10'h000, adcAv = 10'h3c1, adcBv = 10'h0e7;
  logic [9:0] upOut, loOut, upDrv, loDrv, dacA, dacB, upWire, loWire;
  logic upOe, loOe, bclk, adcStrobe, dacAV, dacBV, lowPwr, rxOn, txOn;
  logic [1:0] upsF, bresp, rresp;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] rs;
  int fail_count = 0, checks = 0, cyc = 0, nClk, nV, nS;
  // Bus wires resolved from device enables
  assign upWire = upOe ? upOut : upDrv;
  assign loWire = loOe ? loOut : loDrv;
  // ---------------------------------------------------------------
  // Instances
  // ---------------------------------------------------------------
  fxp_flex_io i_fxp_flex_io (.clk(clk), .rst_n(rst_n), .clkEn(1'b1),
    .serial_enable_strap(serEn), .serial_out_pin(dupS), .serial_data_io_pin(upsH),
    .serial_clk_pin(upsL), .width_strap_pin(widS), .adc_economy_strap(ecoS),
    .select_pin_one(selPin), .receive_sleep_pin(rxSleep), .transmit_sleep_pin(txSleep),
    .upper_half_bus_in(upWire), .upper_half_bus_out(upOut), .upper_half_bus_oe(upOe),
    .lower_half_bus_in(loWire), .lower_half_bus_out(loOut), .lower_half_bus_oe(loOe),
    .buffered_clock_out_pin(bclk), .adcA(adcAv), .adcB(adcBv), .adcStrobe(adcStrobe),
    .dacA(dacA), .dacB(dacB), .dacAValid(dacAV), .dacBValid(dacBV), .adcLowPower(lowPwr),
    .rxAnalogOn(rxOn), .txAnalogOn(txOn), .upsampleFactor(upsF),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  fxp_proc_model i_fxp_proc_model (.clk(clk), .drive(drive), .mark(mark), .word(word),
    .upperDrv(upDrv), .lowerDrv(loDrv));
  // ---------------------------------------------------------------
  // Clock, timeout and tasks
  // ---------------------------------------------------------------
  always #20 clk = ~clk;
  // Cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Write with address and data offered together
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready && awvalid) awvalid <= 1'b0;
      if (wready && wvalid) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    // Let an edge pass so a following call never re-raises in this step
    @(posedge clk);
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready && arvalid) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask
  // Straps are set as reset goes low, three cycles before release
  task automatic do_reset(input logic [5:0] s);
    {serEn, dupS, widS, ecoS, upsH, upsL} <= s;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  task automatic count(input int n);
    nClk = 0;
    nV = 0;
    nS = 0;
    repeat (n) begin
      @(posedge clk);
      nClk += int'(bclk === 1'b1);
      nV += int'(dacAV === 1'b1 || dacBV === 1'b1);
      nS += int'(adcStrobe === 1'b1);
    end
  endtask
  task automatic wait_a();
    repeat (8) if (dacAV !== 1'b1) @(posedge clk);
  endtask
  task automatic wait_b();
    repeat (8) if (dacBV !== 1'b1) @(posedge clk);
  endtask
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    do_reset(6'b011101);
    check(32'(lowPwr), 32'h1);
    check(32'(upsF), 32'(UPS_X2));
    axi_read(ADDR_CFG, rd, rs);
    check(rd, 32'h0000_001d);
    axi_read(ADDR_STAT, rd, rs);
    check(32'(rd[5:4]), 32'(FXP_FULL));
    axi_read(8'h40, rd, rs);
    check(32'(rs), 32'(RESP_SLVERR));
    {ecoS, upsH, upsL} <= 3'b010;
    repeat (6) @(posedge clk);
    check(32'({lowPwr, upsF}), 32'({1'b1, UPS_X2}));
    $display("test 1 done");
    drive <= 1'b1;
    mark <= 1'b1;
    // Full duplex takes the marker from the select pin
    selPin <= 1'b1;
    word <= 10'h2a5;
    repeat (8) @(posedge clk);
    wait_a();
    check(32'(dacA), 32'h2a5);
    mark <= 1'b0;
    selPin <= 1'b0;
    word <= 10'h15a;
    repeat (8) @(posedge clk);
    wait_b();
    check(32'(dacB), 32'h15a);
    count(20);
    check(32'(nClk), 32'd10);
    check(32'(nV), 32'd10);
    rxSleep <= 1'b1;
    repeat (6) @(posedge clk);
    count(20);
    check(32'({nS, rxOn}), 32'h0);
    rxSleep <= 1'b0;
    txSleep <= 1'b1;
    repeat (6) @(posedge clk);
    count(20);
    check(32'({nV, txOn}), 32'h0);
    txSleep <= 1'b0;
    $display("test 2 done");
    for (int i = 1; i >= 0; i--) begin
      do_reset({3'b000, 3'b001} | 6'(i << 3));
      axi_read(ADDR_STAT, rd, rs);
      check(32'(rd[5:4]), 32'(i ? FXP_HD_INTERLEAVED : FXP_HD_PARALLEL));
    end
    drive <= 1'b0;
    repeat (8) @(posedge clk);
    check(32'({upOe, loOe}), 32'h3);
    check(32'({upOut, loOut}), 32'({adcBv, adcAv}));
    selPin <= 1'b1;
    drive <= 1'b1;
    mark <= 1'b1;
    word <= 10'h0c3;
    repeat (8) @(posedge clk);
    check(32'({upOe, loOe}), 32'h0);
    wait_a();
    check(32'({dacA, dacB}), 32'({10'h0c3, 10'h200}));
    $display("test 3 done");
    selPin <= 1'b0;
    drive <= 1'b0;
    do_reset(6'b100000);
    axi_write(ADDR_CTRL, 32'h0000_1231);
    repeat (6) @(posedge clk);
    check(32'({lowPwr, upsF}), 32'({1'b1, UPS_X4}));
    axi_read(ADDR_STAT, rd, rs);
    check(32'(rd[5:3]), 32'({FXP_CLONE, 1'b0}));
    count(40);
    check(32'(nS), 32'd10);
    check(32'(nClk), 32'd10);
    check(32'({upOut, loOut}), 32'({adcBv, adcAv}));
    selPin <= 1'b1;
    drive <= 1'b1;
    mark <= 1'b0;
    word <= 10'h111;
    repeat (8) @(posedge clk);
    wait_b();
    check(32'(dacB), 32'h111);
    check(32'(rxOn), 32'h1);
    $display("test 4 done");
    stop_test();
  end
endmodule // fxp_flex_io_tb
